// *** src/irq_level_map.svh ***
/*
 * register offsets, field positions, reset values and widths of the
 * interrupt level masking and wakeup block.
 * assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
 */
`ifndef IRQ_LEVEL_MAP_SVH
`define IRQ_LEVEL_MAP_SVH

// ==========================================================================
// sizes
`define IRQ_NUM_SRC        8
`define IRQ_SRC_W          3

// ==========================================================================
// register byte offsets
`define IRQ_OFF_SRCMASK    8'h00
`define IRQ_OFF_CPUMASK    8'h04
`define IRQ_OFF_LPCTRL     8'h08
`define IRQ_OFF_MODMASK    8'h0c
`define IRQ_OFF_BUFFLAG    8'h10
`define IRQ_OFF_ACK        8'h14
`define IRQ_OFF_STATUS     8'h18
`define IRQ_OFF_CFG0       8'h20

// ==========================================================================
// fields
`define IRQ_LPCTRL_LVL_LO  4
`define IRQ_LPCTRL_LVL_HI  6
`define IRQ_MODMASK_LO     9
`define IRQ_CFG_PRI_LO     0
`define IRQ_CFG_PRI_HI     2
`define IRQ_CFG_LVL_LO     3
`define IRQ_CFG_LVL_HI     5

// ==========================================================================
// reset values and constants
`define IRQ_SRCMASK_RST    8'hff
`define IRQ_CPUMASK_RST    3'h7
`define IRQ_MODMASK_RST    23'h000000
`define IRQ_CFG_RST        6'h00
`define IRQ_LVL_NMI        3'h7
`define IRQ_WAKE_MAX       3'h6
`define IRQ_VEC_SPURIOUS   8'hff

`endif

// *** src/irq_level_pkg.sv ***
/*
 * types shared by the interrupt level block.
 * assumes irq_level_map.svh for all numeric constants.
 */
package irq_level_pkg;
    typedef logic [2:0] level_t;
    typedef enum logic [2:0] {
        ACK_IDLE = 3'b001,
        ACK_HOLD = 3'b010,
        ACK_DONE = 3'b100
    } ack_state_e;
endpackage : irq_level_pkg

// *** src/irq_level_arbiter.sv ***
/*
 * combinational arbiter: picks the highest level, then highest priority,
 * among requesting sources.
 * assumes each source carries a unique level and priority pair.
 */
`timescale 1ns/1ps
`include "irq_level_map.svh"

module irq_level_arbiter
(
    // candidates
    input  wire logic [`IRQ_NUM_SRC-1:0]   reqVec,
    input  wire logic [`IRQ_NUM_SRC*6-1:0] cfgVec,
    // winner
    output logic                           anyReq,
    output logic [2:0]                     winLevel,
    output logic [`IRQ_SRC_W-1:0]          winSrc
);
    // ======================================================================
    // linear search; a later source wins only with a strictly larger key
    always_comb
    begin
        logic [5:0] bestKey;
        logic [5:0] key;
        bestKey  = 6'h00;
        key      = 6'h00;
        anyReq   = 1'b0;
        winSrc   = '0;
        for (int i = 0; i < `IRQ_NUM_SRC; i++)
        begin
            key = cfgVec[i*6 +: 6];  // level above priority gives ordering
            if (reqVec[i] && (!anyReq || key > bestKey))
            begin
                anyReq  = 1'b1;
                bestKey = key;
                winSrc  = i[`IRQ_SRC_W-1:0];
            end
        end
        winLevel = bestKey[`IRQ_CFG_LVL_HI:`IRQ_CFG_LVL_LO];
    end
endmodule : irq_level_arbiter

// *** src/irq_level_ctrl.sv ***
/*
 * interrupt level masking, spurious acknowledge and wakeup logic.
 * assumes synchronous level requests from peripherals, a classic wishbone
 * master, and a core that pulses ackReq after seeing irqLevel nonzero.
 */
// The implementer's own choices: the address map and the Wishbone slave port.
// What this block does
// - requests below level 7 at or below the core's current mask level are blocked.
// - level 7 requests, the edge-sensitive one and sources set to level 7, always pass the core mask.
// - an acknowledge with no identifiable source returns the spurious vector.
// - wakeup level comes from low-power control bits 6:4, adjusted so level 7 wakes.
// - the applied wakeup mask is limited to 0 through 6.
// - a source config at reset value keeps that source disabled.
// - module mask bits 16:9 mask when zero and pass when one; bits 31:17 are stored only.
// - a buffer done flag clears only on write-one after a read of one.
`timescale 1ns/1ps
`include "irq_level_map.svh"

module irq_level_ctrl
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    // wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // peripheral requests and buffer events
    input  wire logic [`IRQ_NUM_SRC-1:0] srcReq,
    input  wire logic [7:0]              bufDoneSet,
    input  wire logic                    nmiEdgeIn,
    // core side
    input  wire logic                    ackReq,
    output logic      [2:0]              irqLevel,
    output logic      [7:0]              ackVector,
    output logic                         ackValid,
    output logic                         wakeReq
);
    // ======================================================================
    // registers
    logic [`IRQ_NUM_SRC-1:0]   srcMask_q;
    irq_level_pkg::level_t     cpuMask_q;
    logic [6:0]                lpCtrl_q;
    logic [22:0]               modMask_q;
    logic [7:0]                bufFlag_q;
    logic [7:0]                bufSeen_q;
    logic [`IRQ_NUM_SRC*6-1:0] cfg_q;
    logic                      nmiPrev_q;
    logic                      nmiPend_q;

    // the module mask bits 16:9 gate the sources in order from bit 9
    function automatic logic modPass(input logic [22:0] m, input int idx);
        modPass = m[idx];
    endfunction : modPass

    function automatic logic cfgEnabled(input logic [5:0] c);
        cfgEnabled = c[`IRQ_CFG_LVL_HI:`IRQ_CFG_LVL_LO] != 3'h0;
    endfunction : cfgEnabled

    // ======================================================================
    // bus decode
    logic wbReq;
    logic wbWr;
    logic wbRd;
    logic isCfg;
    logic [`IRQ_SRC_W-1:0] cfgIdx;
    assign wbReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wbWr   = wbReq && wb_we_i;
    assign wbRd   = wbReq && !wb_we_i;
    assign isCfg  = wb_adr_i[7:5] == 3'(`IRQ_OFF_CFG0 >> 5);
    assign cfgIdx = wb_adr_i[`IRQ_SRC_W+1:2];

    // ======================================================================
    // source qualification
    logic [`IRQ_NUM_SRC-1:0] gated;
    genvar g;
    generate
        for (g = 0; g < `IRQ_NUM_SRC; g++)
        begin : gSrc
            logic [2:0] lvl;
            assign lvl = cfg_q[g*6+`IRQ_CFG_LVL_LO +: 3];
            // zero level disables zero mask bits block
            assign gated[g] = srcReq[g] && cfgEnabled(cfg_q[g*6 +: 6]) && srcMask_q[g]
                           && modPass(modMask_q, g)
                           && ((lvl > cpuMask_q) || (lvl == `IRQ_LVL_NMI));
        end
    endgenerate

    logic       anyReq;
    logic [2:0] winLevel;
    logic [`IRQ_SRC_W-1:0] winSrc;

    irq_level_arbiter uArb
    (
        .reqVec   (gated),
        .cfgVec   (cfg_q),
        .anyReq   (anyReq),
        .winLevel (winLevel),
        .winSrc   (winSrc)
    );

    // ======================================================================
    // wakeup level, clamped so a level 7 request always gets through
    logic [2:0] wakeLvl;
    logic       nmiActive;
    assign wakeLvl   = (lpCtrl_q[`IRQ_LPCTRL_LVL_HI:`IRQ_LPCTRL_LVL_LO] > `IRQ_WAKE_MAX)
                     ? `IRQ_WAKE_MAX
                     : lpCtrl_q[`IRQ_LPCTRL_LVL_HI:`IRQ_LPCTRL_LVL_LO];
    assign nmiActive = nmiPend_q;

    // ======================================================================
    // software registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            srcMask_q <= `IRQ_SRCMASK_RST;
            cpuMask_q <= `IRQ_CPUMASK_RST;
            lpCtrl_q  <= 7'h00;
            modMask_q <= `IRQ_MODMASK_RST;
        end
        else if (wbWr)
        begin
            if (wb_adr_i == `IRQ_OFF_SRCMASK && wb_sel_i[0])
                srcMask_q <= wb_dat_i[7:0];
            if (wb_adr_i == `IRQ_OFF_CPUMASK && wb_sel_i[0])
                cpuMask_q <= wb_dat_i[2:0];
            if (wb_adr_i == `IRQ_OFF_LPCTRL && wb_sel_i[0])
                lpCtrl_q  <= wb_dat_i[6:0];
            if (wb_adr_i == `IRQ_OFF_MODMASK)
            begin
                if (wb_sel_i[1])
                    modMask_q[6:0]   <= wb_dat_i[15:9];
                if (wb_sel_i[2])
                    modMask_q[14:7]  <= wb_dat_i[23:16];
                if (wb_sel_i[3])
                    modMask_q[22:15] <= wb_dat_i[31:24];
            end
        end
    end

    // per-source level and priority, reset value means disabled
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cfg_q <= '0;
        else if (wbWr && isCfg && wb_sel_i[0])
            cfg_q[cfgIdx*6 +: 6] <= wb_dat_i[5:0];
    end

    // ======================================================================
    // buffer done flags: set beats clear, clear needs a prior read of one
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bufFlag_q <= 8'h00;
            bufSeen_q <= 8'h00;
        end
        else
        begin
            if (wbRd && wb_adr_i == `IRQ_OFF_BUFFLAG)
                bufSeen_q <= bufSeen_q | bufFlag_q;
            for (int i = 0; i < 8; i++)
            begin
                if (bufDoneSet[i])
                    bufFlag_q[i] <= 1'b1;
                else if (wbWr && wb_adr_i == `IRQ_OFF_BUFFLAG && wb_sel_i[0]
                         && wb_dat_i[i] && bufSeen_q[i])
                begin
                    bufFlag_q[i] <= 1'b0;
                    bufSeen_q[i] <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // level 7 edge capture, cleared by a core acknowledge at level 7 while no qualified source is requesting (anyReq low)
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmiPrev_q <= 1'b0;
            nmiPend_q <= 1'b0;
        end
        else
        begin
            nmiPrev_q <= nmiEdgeIn;
            if (nmiEdgeIn && !nmiPrev_q)
                nmiPend_q <= 1'b1;
            else if (ackReq && irqLevel == `IRQ_LVL_NMI && !anyReq)
                nmiPend_q <= 1'b0;
        end
    end

    // ======================================================================
    // core outputs: level presented, acknowledge answered from live state
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqLevel  <= 3'h0;
            ackVector <= 8'h00;
            ackValid  <= 1'b0;
            wakeReq   <= 1'b0;
        end
        else
        begin
            irqLevel <= nmiActive ? `IRQ_LVL_NMI : (anyReq ? winLevel : 3'h0);
            wakeReq  <= nmiActive || (anyReq && winLevel > wakeLvl);
            ackValid <= ackReq;
            if (ackReq)
            begin
                // masking after signalling leaves nothing to name
                if (anyReq && winLevel == irqLevel)
                    ackVector <= {5'h00, winSrc};
                else
                    ackVector <= `IRQ_VEC_SPURIOUS;
            end
        end
    end

    // ======================================================================
    // wishbone answer, one wait state, unmapped reads give zero
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h00000000;
            if (wbRd)
            begin
                if (isCfg)
                    wb_dat_o <= {26'h0, cfg_q[cfgIdx*6 +: 6]};
                else
                    case (wb_adr_i)
                        `IRQ_OFF_SRCMASK: wb_dat_o <= {24'h0, srcMask_q};
                        `IRQ_OFF_CPUMASK: wb_dat_o <= {29'h0, cpuMask_q};
                        `IRQ_OFF_LPCTRL:  wb_dat_o <= {25'h0, lpCtrl_q};
                        `IRQ_OFF_MODMASK: wb_dat_o <= {modMask_q, 9'h000};
                        `IRQ_OFF_BUFFLAG: wb_dat_o <= {24'h0, bufFlag_q};
                        `IRQ_OFF_STATUS:  wb_dat_o <= {20'h0, wakeLvl, 1'b0, irqLevel,
                                                       1'b0, nmiPend_q, winSrc};
                        default:          wb_dat_o <= 32'h00000000;
                    endcase
            end
        end
    end
endmodule : irq_level_ctrl

// *** bench/irq_core_model.sv ***
/* core model: latches a presented level once per enable and acknowledges it
   ackDelay+1 cycles later. assumes irqLevel comes from irq_level_ctrl. */
`timescale 1ns/1ps
module irq_core_model
(
    // clock, reset and bench control
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       coreEn,
    input  wire logic [7:0] ackDelay,
    // device side
    input  wire logic [2:0] irqLevel,
    output logic            ackReq
);
    logic       busyQ;
    logic       armQ;
    logic [7:0] cntQ;
    // =====
    // the level is kept once seen, so a late mask makes the answer spurious
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
            busyQ  <= 1'b0;
            armQ   <= 1'b1;
            cntQ   <= 8'h00;
            ackReq <= 1'b0;
        end
        else
        begin
            ackReq <= busyQ && cntQ == 8'h00;
            if (!coreEn)
                armQ <= 1'b1;
            if (busyQ)
                cntQ <= cntQ - 8'h01;
            if (busyQ && cntQ == 8'h00)
                busyQ <= 1'b0;
            else if (coreEn && armQ && irqLevel != 3'h0)
            begin
                busyQ <= 1'b1;
                armQ  <= 1'b0;
                cntQ  <= ackDelay;
            end
        end
endmodule : irq_core_model

// *** bench/irq_level_ctrl_checker.sv ***
/* checker of the irq_level_ctrl port relations.
   assumes it is bound to the design; the core mask is mirrored from writes. */
`timescale 1ns/1ps
module irq_level_ctrl_checker
(
    // clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    // core side
    input wire logic        nmiEdgeIn,
    input wire logic        ackReq,
    input wire logic [2:0]  irqLevel,
    input wire logic [7:0]  ackVector,
    input wire logic        ackValid,
    input wire logic        wakeReq
);
    logic [2:0] maskQ;
    // =====
    // mirror lags the design by one cycle, hence the two-cycle settle below
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            maskQ <= 3'h7;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0])
            maskQ <= wb_dat_i[2:0];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held too long");
    a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing");
    a_answer_prompt: assert property (ackReq |=> ackValid)
        else $error("core ack unanswered");
    a_answer_cause: assert property (ackValid |-> $past(ackReq))
        else $error("answer without core ack");
    a_level_above_mask: assert property
        (irqLevel != 3'h0 && irqLevel != 3'h7 && $past(maskQ, 2) == maskQ
        |-> irqLevel > maskQ) else $error("level at or below core mask");
    a_nmi_presented: assert property ($rose(nmiEdgeIn) |-> ##[1:3] irqLevel == 3'h7)
        else $error("level 7 edge not presented");
    a_seven_wakes: assert property (irqLevel == 3'h7 |-> ##[0:1] wakeReq)
        else $error("level 7 without wakeup");
    a_spurious_idle: assert property (ackReq && irqLevel == 3'h0 |=> ackVector == 8'hff)
        else $error("empty ack not spurious");
    a_vector_range: assert property
        (ackValid |-> ackVector == 8'hff || ackVector < 8'h08) else $error("bad vector");

    c_spurious: cover property (ackValid && ackVector == 8'hff);
    c_named: cover property (ackValid && ackVector < 8'h08);
    c_wake: cover property ($rose(wakeReq));
endmodule : irq_level_ctrl_checker

bind irq_level_ctrl irq_level_ctrl_checker chk (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .nmiEdgeIn, .ackReq, .irqLevel,
    .ackVector, .ackValid, .wakeReq);

// *** bench/interrupt_level_masking_and_wakeup_bench.sv ***
/* bench of irq_level_ctrl against an integer model, with a core model.
   assumes the core model and checker files are compiled before it. */
`timescale 1ns/1ps
module interrupt_level_masking_and_wakeup_bench;
    logic        ref_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic        nmiEdgeIn = 0, coreEn = 0, ackReq, ackValid, wakeReq, wb_ack_o;
    logic [2:0]  irqLevel;
    logic [7:0]  wb_adr_i = 0, bufDoneSet = 0, srcReq = 0, ackDelay = 0, ackVector, sm;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rq, mm, seed = 32'h5fe96f33;
    int          err_total = 0, num_checks = 0, lv[8], pr[8], cm, wl, ws, nmiP = 0;
    // =====
    // design and far side
    always #25 ref_clk = ~ref_clk;
    irq_level_ctrl dut (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .srcReq, .bufDoneSet,
        .nmiEdgeIn, .ackReq, .irqLevel, .ackVector, .ackValid, .wakeReq);
    irq_core_model core (.ref_clk, .rstn, .coreEn, .ackDelay, .irqLevel, .ackReq);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // one classic cycle; ack and read data are taken at the rising edge, then released
    task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rq = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge ref_clk);
    endtask : bus
    // integer model: highest level over the core mask, 7 always, then priority
    task automatic look();
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        wl = nmiP ? 7 : 0;
        ws = 255;
        for (int i = 0; i < 8; i++)
            if (srcReq[i] && sm[i] && mm[i+9] && lv[i] > 0 && (lv[i] > cm || lv[i] == 7)
                && (lv[i] > wl || ws < 8 && lv[i] == wl && pr[i] > pr[ws]))
            begin
                wl = lv[i];
                ws = i;
            end
        chk("level", wl, irqLevel);
        @(posedge ref_clk);
    endtask : look
    task automatic ack_check(logic [7:0] dly, logic [7:0] e);
        int n;
        n = 0;
        ackDelay <= dly;
        coreEn <= 1;
        do @(negedge ref_clk); while (ackValid !== 1'b1 && ++n < 300);
        chk("ack valid", 1, ackValid);
        chk("vector", e, ackVector);
        @(posedge ref_clk);
        coreEn <= 0;
        @(posedge ref_clk);
    endtask : ack_check

    initial
    begin
        #500_000;
        err_total++;
        end_sim();
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1;
        @(posedge ref_clk);
        // reset values, an unmapped place, and unprogrammed sources staying quiet
        bus(0, 8'h00, 0);
        chk("srcmask", 32'hff, rq);
        bus(0, 8'h04, 0);
        chk("cpumask", 32'h7, rq);
        bus(1, 8'h14, 32'h5a);
        bus(0, 8'h14, 0);
        chk("unmapped", 0, rq);
        bus(1, 8'h0c, 32'hffff_fe00);
        bus(1, 8'h04, 0);
        srcReq <= 8'hff;
        look();
        for (int t = 0; t < 16; t++)
        begin
            srcReq <= 0; // masks change only while nothing is signalled
            sm = 8'(rnd());
            mm = rnd();
            cm = rnd() % 8;
            bus(1, 8'h00, sm);
            bus(1, 8'h04, cm);
            bus(1, 8'h0c, mm);
            for (int i = 0; i < 8; i++)
            begin
                lv[i] = rnd() % 8;
                pr[i] = i ^ 5;
                bus(1, 8'(8'h20 + 4 * i), lv[i] * 8 + pr[i]);
            end
            srcReq <= 8'(rnd());
            look();
            if (wl > 0)
                ack_check(8'(rnd() % 4), 8'(ws));
        end
        // source 2 at level 3 masked between signal and acknowledge
        sm = 8'hff;
        mm = 32'hffff_fe00;
        cm = 0;
        bus(1, 8'h00, sm);
        bus(1, 8'h04, 0);
        bus(1, 8'h0c, mm);
        lv[2] = 3;
        bus(1, 8'h28, 32'h1a);
        srcReq <= 8'h04;
        look();
        ackDelay <= 40;
        coreEn <= 1;
        @(posedge ref_clk);
        bus(1, 8'h00, 8'hfb);
        ack_check(40, 8'hff);
        bus(1, 8'h00, 8'hff);
        bus(1, 8'h04, 7);
        bus(1, 8'h00, 8'hfb);
        bus(1, 8'h04, 0);
        sm = 8'hfb;
        look();
        bus(1, 8'h00, 8'hff);
        for (int v = 0; v < 8; v++)
        begin
            bus(1, 8'h08, v << 4);
            bus(0, 8'h18, 0);
            chk("wake level", v > 6 ? 6 : v, rq[11:9]);
            chk("status level", 3, rq[7:5]);
            chk("wake", 3 > (v > 6 ? 6 : v), wakeReq);
        end
        // level 7 edge under a full core mask, wake level clamped to 6
        srcReq <= 0;
        bus(1, 8'h04, 7);
        cm = 7;
        nmiEdgeIn <= 1;
        nmiP = 1;
        look();
        chk("wake", 1, wakeReq);
        ack_check(0, 8'hff);
        nmiP = 0;
        nmiEdgeIn <= 0;
        look();
        // buffer flags clear only by a one written after a read of one
        bufDoneSet <= 8'h28;
        @(posedge ref_clk);
        bufDoneSet <= 0;
        bus(0, 8'h10, 0);
        chk("flags", 8'h28, rq);
        bus(1, 8'h10, 8'h08);
        bus(0, 8'h10, 0);
        chk("flags", 8'h20, rq);
        bufDoneSet <= 8'h02;
        @(posedge ref_clk);
        bufDoneSet <= 0;
        bus(1, 8'h10, 8'h02);
        bus(0, 8'h10, 0);
        chk("flags", 8'h22, rq);
        bus(1, 8'h10, 8'h22);
        bus(0, 8'h10, 0);
        chk("flags", 0, rq);
        end_sim();
    end
endmodule : interrupt_level_masking_and_wakeup_bench
